//--- core/led_defines.svh
`ifndef LED_DEFINES_SVH
`define LED_DEFINES_SVH
// Functional notes
// [RULE1] Two supplies: both green, one yellow, none dark.
// [RULE2] Single supply: present green, absent dark.
// [RULE3] Standby LED green when standby enabled, else dark.
// [RULE4] Ring LED: off dark, blocked green, forwarding yellow.
// [RULE5] Ring LED flashes green on wrong ring.
// [RULE6] Storage error: ring and standby flash alternately.
// [RULE7] Copy into device: both flash twice per period.
// [RULE8] Copy onto storage: both flash once per period.
// [RULE9] Fault red while relay one reports error.
// [RULE10] New release: fault flashes four times on IP conflict.
// [RULE11] Old release: relay LED yellow closed manual.
// [RULE12] New release: open auto green, manual yellow.
// [RULE13] Manual relay: fault follows errors, not contact.
// [RULE14] Port: no link dark, link green, traffic yellow flash.
// [RULE15] Port standby: green flashes once per period.
// [RULE16] Port disabled: green flashes three times per period.
// [RULE17] Boot phase: port LEDs show boot progress.
// [RULE18] Power-up: init then self-test, LEDs lit.
// [RULE19] All flashes share one flash-period timebase.

// Flash period length and slot count.
`define FLASH_PERIOD_NS   64'd1000000000
`define CLK_PERIOD_NS     64'd5
`define FLASH_SLOTS       16
`define SLOT_CYCLES       ((`FLASH_PERIOD_NS / `CLK_PERIOD_NS) / `FLASH_SLOTS)
// Init and self-test phase lengths in flash periods.
`define INIT_PERIODS      4'h2
`define SELFTEST_PERIODS  4'h2
`endif

//--- core/led_pkg.sv
package led_pkg;
  // LED colour codes.
  typedef enum logic [1:0] {
    LED_OFF,
    LED_GREEN,
    LED_YELLOW,
    LED_RED
  } led_color_t;

  // Power-up phases.
  typedef enum logic [1:0] {
    PH_INIT,
    PH_SELFTEST,
    PH_BOOT,
    PH_RUN
  } phase_t;

  // Storage operation codes.
  typedef enum logic [1:0] {
    MEM_IDLE,
    MEM_ERROR,
    MEM_LOAD,
    MEM_SAVE
  } mem_op_t;
endpackage : led_pkg

//--- core/flash_if.sv
`timescale 1ns/1ps
// Shared flash timebase signals.
interface flash_if;
  logic       slot_tick;
  logic [3:0] slot;
  logic       period_tick;
  modport source (output slot_tick, output slot, output period_tick);
  modport sink   (input slot_tick, input slot, input period_tick);
endinterface : flash_if

//--- core/flash_timebase.sv
`timescale 1ns/1ps
`include "led_defines.svh"
// Divides the clock into flash slots; one period is sixteen slots.
module flash_timebase #(
  parameter int unsigned SLOT_CYCLES = 32'(`SLOT_CYCLES)
) (
  input  wire logic mclk_i,
  input  wire logic rstn_i,
  flash_if.source   tb
);
  typedef struct packed {
    logic [31:0] cnt;
    logic [3:0]  slot;
    logic        tick;
  } tb_state_t;

  tb_state_t st;
  tb_state_t next_st;

  // One shared counter drives every flash pattern.
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    if (st.cnt >= 32'(SLOT_CYCLES - 1)) begin // RULE19
      next_st.cnt  = 32'h0;
      next_st.slot = st.slot + 4'h1;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tb.slot_tick   = st.tick;
  assign tb.slot        = st.slot;
  assign tb.period_tick = st.tick && (st.slot == 4'h0);

  a_slot_wrap : assert property (@(posedge mclk_i) disable iff (!rstn_i)
    st.tick |-> st.cnt == 32'h0) else $error("slot counter did not wrap"); // RULE19
endmodule : flash_timebase

//--- core/status_led_indicator.sv
`timescale 1ns/1ps
`include "led_defines.svh"
// Front-panel status LED driver.
module status_led_indicator
  import led_pkg::*;
#(
  parameter int unsigned NUM_PORTS   = 16,
  parameter int unsigned SLOT_CYCLES = 32'(`SLOT_CYCLES),
  parameter bit          DUAL_SUPPLY = 1'b1
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  supply1_ok_i,
  input  wire logic                  supply2_ok_i,
  input  wire logic                  standby_en_i,
  input  wire logic                  ring_mgr_en_i,
  input  wire logic                  ring_port_blocked_i,
  input  wire logic                  ring_misconfig_i,
  input  wire led_pkg::mem_op_t      mem_op_i,
  input  wire logic                  new_release_i,
  input  wire logic                  ip_conflict_i,
  input  wire logic                  relay1_error_i,
  input  wire logic [1:0]            relay_open_i,
  input  wire logic [1:0]            relay_manual_i,
  input  wire logic                  boot_done_i,
  input  wire logic [NUM_PORTS-1:0]  port_link_i,
  input  wire logic [NUM_PORTS-1:0]  port_activity_i,
  input  wire logic [NUM_PORTS-1:0]  port_standby_i,
  input  wire logic [NUM_PORTS-1:0]  port_disabled_i,
  output led_pkg::led_color_t        power_led_o,
  output led_pkg::led_color_t        standby_led_o,
  output led_pkg::led_color_t        ring_manager_led_o,
  output led_pkg::led_color_t        fault_led_o,
  output led_pkg::led_color_t        relay_one_led_o,
  output led_pkg::led_color_t        relay_two_led_o,
  output logic [NUM_PORTS-1:0]       port_link_led_o,
  output logic [NUM_PORTS-1:0]       port_traffic_led_o,
  output led_pkg::phase_t            phase_o
);
  import led_pkg::*;

  // ************************************************************
  // Timebase
  // ************************************************************
  flash_if fl ();

  flash_timebase #(
    .SLOT_CYCLES (SLOT_CYCLES)
  ) u_timebase (
    .mclk_i (mclk_i),
    .rstn_i (rstn_i),
    .tb     (fl.source)
  );

  // ************************************************************
  // Pattern decode
  // ************************************************************
  // Each flash of a multi-flash pattern is one lit slot followed by one dark slot; a single flash lights slots 0 and 1.
  logic blink_1x;
  logic blink_2x;
  logic blink_3x;
  logic blink_4x;
  logic half_a;
  logic fast;

  // Counted flashes start at slot 0 and repeat each period.
  always_comb begin
    blink_1x = (fl.slot == 4'h0) || (fl.slot == 4'h1); // RULE19
    blink_2x = ~fl.slot[0] && (fl.slot < 4'h4);
    blink_3x = ~fl.slot[0] && (fl.slot < 4'h6);
    blink_4x = ~fl.slot[0] && (fl.slot < 4'h8);
    half_a   = ~fl.slot[3];
    fast     = ~fl.slot[1];
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    phase_t                phase;
    logic [3:0]            periods;
    logic [3:0]            boot_step;
    led_color_t            power;
    led_color_t            standby;
    led_color_t            ring;
    led_color_t            fault;
    led_color_t            relay1;
    led_color_t            relay2;
    logic [NUM_PORTS-1:0]  link_led;
    logic [NUM_PORTS-1:0]  traffic_led;
  } led_state_t;

  led_state_t st;
  led_state_t next_st;

  // Relay LED colour for one contact in either release scheme.
  function automatic led_color_t relay_color(input logic open_c, input logic manual_c,
                                             input logic new_rel);
    led_color_t c;
    c = LED_OFF;
    if (new_rel) begin
      if (open_c) begin
        c = manual_c ? LED_YELLOW : LED_GREEN; // RULE12
      end
    end else if (manual_c && !open_c) begin
      c = LED_YELLOW; // RULE11
    end
    return c;
  endfunction : relay_color

  // Next-state logic for phases and all LED colours.
  always_comb begin
    next_st = st;

    // Power-up runs init, then self-test, then boot until software is up.
    if (fl.period_tick) begin
      case (st.phase)
        PH_INIT: begin
          if (st.periods == `INIT_PERIODS - 4'h1) begin // RULE18
            next_st.phase   = PH_SELFTEST;
            next_st.periods = 4'h0;
          end else begin
            next_st.periods = st.periods + 4'h1;
          end
        end
        PH_SELFTEST: begin
          if (st.periods == `SELFTEST_PERIODS - 4'h1) begin // RULE18
            next_st.phase   = PH_BOOT;
            next_st.periods = 4'h0;
          end else begin
            next_st.periods = st.periods + 4'h1;
          end
        end
        PH_BOOT: begin
          next_st.boot_step = st.boot_step + 4'h1;
        end
        PH_RUN: begin
          next_st.periods = 4'h0;
        end
        default: begin
          next_st.phase = PH_INIT;
        end
      endcase
    end
    if (st.phase == PH_BOOT && boot_done_i) begin
      next_st.phase = PH_RUN;
    end

    // Power LED.
    if (DUAL_SUPPLY) begin
      if (supply1_ok_i && supply2_ok_i) begin
        next_st.power = LED_GREEN; // RULE1
      end else if (supply1_ok_i || supply2_ok_i) begin
        next_st.power = LED_YELLOW; // RULE1
      end else begin
        next_st.power = LED_OFF; // RULE1
      end
    end else begin
      next_st.power = supply1_ok_i ? LED_GREEN : LED_OFF; // RULE2
    end

    // Standby and ring manager LEDs; storage operations override both.
    next_st.standby = standby_en_i ? LED_GREEN : LED_OFF; // RULE3
    if (!ring_mgr_en_i) begin
      next_st.ring = LED_OFF; // RULE4
    end else if (ring_misconfig_i) begin
      next_st.ring = fast ? LED_GREEN : LED_OFF; // RULE5
    end else begin
      next_st.ring = ring_port_blocked_i ? LED_GREEN : LED_YELLOW; // RULE4
    end
    case (mem_op_i)
      MEM_ERROR: begin
        next_st.ring    = half_a ? LED_GREEN : LED_OFF; // RULE6
        next_st.standby = half_a ? LED_OFF : LED_GREEN; // RULE6
      end
      MEM_LOAD: begin
        next_st.ring    = blink_2x ? LED_GREEN : LED_OFF; // RULE7
        next_st.standby = blink_2x ? LED_GREEN : LED_OFF; // RULE7
      end
      MEM_SAVE: begin
        next_st.ring    = blink_1x ? LED_GREEN : LED_OFF; // RULE8
        next_st.standby = blink_1x ? LED_GREEN : LED_OFF; // RULE8
      end
      default: begin
      end
    endcase

    // Fault follows the error report and, in the new release, the IP conflict; never a manual contact setting.
    if (relay1_error_i) begin
      next_st.fault = LED_RED; // RULE9 RULE13
    end else if (new_release_i && ip_conflict_i) begin
      next_st.fault = blink_4x ? LED_RED : LED_OFF; // RULE10
    end else begin
      next_st.fault = LED_OFF; // RULE9
    end
    next_st.relay1 = relay_color(relay_open_i[0], relay_manual_i[0], new_release_i);
    next_st.relay2 = relay_color(relay_open_i[1], relay_manual_i[1], new_release_i);

    // Port indicators; boot shows a growing progress bar instead.
    for (int i = 0; i < NUM_PORTS; i++) begin
      next_st.link_led[i]    = 1'b0;
      next_st.traffic_led[i] = 1'b0;
      if (st.phase != PH_RUN) begin
        next_st.link_led[i] = (i <= int'(st.boot_step)) && (st.phase == PH_BOOT); // RULE17
        next_st.traffic_led[i] = (st.phase != PH_BOOT); // RULE18
      end else if (port_disabled_i[i]) begin
        next_st.link_led[i] = blink_3x; // RULE16
      end else if (port_standby_i[i]) begin
        next_st.link_led[i] = blink_1x; // RULE15
      end else if (port_link_i[i]) begin
        next_st.link_led[i]    = ~port_activity_i[i] | fast; // RULE14
        next_st.traffic_led[i] = port_activity_i[i] & ~fast; // RULE14
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rstn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign power_led_o        = st.power;
  assign standby_led_o      = st.standby;
  assign ring_manager_led_o = st.ring;
  assign fault_led_o        = st.fault;
  assign relay_one_led_o    = st.relay1;
  assign relay_two_led_o    = st.relay2;
  assign port_link_led_o    = st.link_led;
  assign port_traffic_led_o = st.traffic_led;
  assign phase_o            = st.phase;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  a_power_both : assert property (DUAL_SUPPLY && supply1_ok_i && supply2_ok_i
    |=> power_led_o == LED_GREEN) else $error("power not green"); // RULE1
  a_power_one : assert property (DUAL_SUPPLY && (supply1_ok_i ^ supply2_ok_i)
    |=> power_led_o == LED_YELLOW) else $error("power not yellow"); // RULE1
  a_power_single : assert property (!DUAL_SUPPLY && !supply1_ok_i
    |=> power_led_o == LED_OFF) else $error("power not dark"); // RULE2
  a_standby_on : assert property (mem_op_i == MEM_IDLE && standby_en_i
    |=> standby_led_o == LED_GREEN) else $error("standby not green"); // RULE3
  a_ring_off : assert property (mem_op_i == MEM_IDLE && !ring_mgr_en_i
    |=> ring_manager_led_o == LED_OFF) else $error("ring not dark"); // RULE4
  a_ring_misconf : assert property (mem_op_i == MEM_IDLE && ring_mgr_en_i
    && ring_misconfig_i |=> ring_manager_led_o != LED_YELLOW)
    else $error("ring misconfig shows yellow"); // RULE5
  a_mem_alt : assert property (mem_op_i == MEM_ERROR |=>
    (ring_manager_led_o == LED_OFF) != (standby_led_o == LED_OFF))
    else $error("storage error not alternate"); // RULE6
  a_mem_sync : assert property (mem_op_i inside {MEM_LOAD, MEM_SAVE} |=>
    ring_manager_led_o == standby_led_o) else $error("storage flash not together"); // RULE7
  a_fault_err : assert property (relay1_error_i |=> fault_led_o == LED_RED)
    else $error("fault not red"); // RULE9
  a_fault_man : assert property (!relay1_error_i && !ip_conflict_i
    |=> fault_led_o == LED_OFF) else $error("fault follows contact"); // RULE13
  a_relay_new : assert property (new_release_i && relay_open_i[0] && !relay_manual_i[0]
    |=> relay_one_led_o == LED_GREEN) else $error("relay not green"); // RULE12
  a_relay_old : assert property (!new_release_i && relay_manual_i[0] && !relay_open_i[0]
    |=> relay_one_led_o == LED_YELLOW) else $error("relay not yellow"); // RULE11
  a_port_dark : assert property (phase_o == PH_RUN && !port_link_i[0]
    && !port_disabled_i[0] && !port_standby_i[0] |=> !port_link_led_o[0]
    && !port_traffic_led_o[0]) else $error("port not dark"); // RULE14
  a_boot_init : assert property (phase_o == PH_INIT |-> ##1 phase_o
    inside {PH_INIT, PH_SELFTEST}) else $error("init skipped"); // RULE18

  c_mem_load : cover property (mem_op_i == MEM_LOAD ##1 ring_manager_led_o == LED_GREEN);
  c_ip_flash : cover property (fault_led_o == LED_RED && ip_conflict_i);
  c_boot_run : cover property (phase_o == PH_BOOT ##1 phase_o == PH_RUN);
  c_port_dis : cover property (port_disabled_i[0] && port_link_led_o[0]);
endmodule : status_led_indicator

//--- dv/led_viewer.sv
`timescale 1ns/1ps
// ****************************************
// Operator view of six front-panel LEDs
// ****************************************
module led_viewer (
  input  wire logic        mclk_i,
  input  wire logic        clear_i,
  input  wire logic [11:0] colors_i,
  output int               lit_o[6],
  output int               rises_o[6],
  output logic [1:0]       hue_o[6],
  output int               both_o
);
  logic [11:0] prev;

  // Counts lit cycles, flash starts and last colour of each LED in a window.
  always_ff @(posedge mclk_i) begin
    prev <= colors_i;
    both_o <= clear_i ? 0 : both_o + int'(colors_i[1:0] != 2'h0 && colors_i[3:2] != 2'h0);
    for (int i = 0; i < 6; i++) begin
      if (clear_i) begin
        lit_o[i] <= 0;
        rises_o[i] <= 0;
        hue_o[i] <= 2'h0;
      end else if (colors_i[2*i+:2] != 2'h0) begin
        lit_o[i] <= lit_o[i] + 1;
        rises_o[i] <= rises_o[i] + int'(prev[2*i+:2] == 2'h0);
        hue_o[i] <= colors_i[2*i+:2];
      end
    end
  end
endmodule : led_viewer

//--- dv/test_status_led_indicator.sv
`timescale 1ns/1ps
module test_status_led_indicator;
  import led_pkg::*;
  localparam int SC  = 4;
  localparam int PER = 16 * SC;
  logic        mclk_i;
  logic        rstn_i = 1'b0;
  logic        supply1_ok_i = 1'b0, supply2_ok_i = 1'b0, standby_en_i = 1'b0;
  logic        ring_mgr_en_i = 1'b0, ring_port_blocked_i = 1'b0, ring_misconfig_i = 1'b0;
  logic        new_release_i = 1'b0, ip_conflict_i = 1'b0, relay1_error_i = 1'b0;
  logic        boot_done_i = 1'b0, clear = 1'b0;
  logic [1:0]  relay_open_i = 2'h0, relay_manual_i = 2'h0;
  logic [15:0] port_link_i = 16'hffff, port_activity_i = 16'h0000;
  logic [15:0] port_standby_i = 16'h0000, port_disabled_i = 16'h0000;
  logic [15:0] port_link_led_o, port_traffic_led_o;
  mem_op_t     mem_op_i = MEM_IDLE;
  phase_t      phase_o;
  led_color_t  power_led_o, standby_led_o, ring_manager_led_o;
  led_color_t  fault_led_o, relay_one_led_o, relay_two_led_o, power_single;
  led_color_t  pw[4] = '{LED_OFF, LED_YELLOW, LED_YELLOW, LED_GREEN};
  int          lit[6], rises[6], both, mismatches = 0, tests_run = 0;
  logic [1:0]  hue[6];

  status_led_indicator #(.SLOT_CYCLES(SC)) dut_u (.mclk_i, .rstn_i, .supply1_ok_i,
    .supply2_ok_i, .standby_en_i, .ring_mgr_en_i, .ring_port_blocked_i, .ring_misconfig_i,
    .mem_op_i, .new_release_i, .ip_conflict_i, .relay1_error_i, .relay_open_i,
    .relay_manual_i, .boot_done_i, .port_link_i, .port_activity_i, .port_standby_i,
    .port_disabled_i, .power_led_o, .standby_led_o, .ring_manager_led_o, .fault_led_o,
    .relay_one_led_o, .relay_two_led_o, .port_link_led_o, .port_traffic_led_o, .phase_o);

  // Single-supply variant; only its power LED is compared.
  status_led_indicator #(.SLOT_CYCLES(SC), .DUAL_SUPPLY(1'b0)) single_u (.mclk_i, .rstn_i,
    .supply1_ok_i, .supply2_ok_i, .standby_en_i, .ring_mgr_en_i, .ring_port_blocked_i,
    .ring_misconfig_i, .mem_op_i, .new_release_i, .ip_conflict_i, .relay1_error_i,
    .relay_open_i, .relay_manual_i, .boot_done_i, .port_link_i, .port_activity_i,
    .port_standby_i, .port_disabled_i, .power_led_o(power_single), .standby_led_o(),
    .ring_manager_led_o(), .fault_led_o(), .relay_one_led_o(), .relay_two_led_o(),
    .port_link_led_o(), .port_traffic_led_o(), .phase_o());

  led_viewer eye_u (.mclk_i(mclk_i), .clear_i(clear), .colors_i({1'b0, port_traffic_led_o[0],
    1'b0, port_link_led_o[0], relay_one_led_o, fault_led_o, standby_led_o,
    ring_manager_led_o}), .lit_o(lit), .rises_o(rises), .hue_o(hue), .both_o(both));

  // ****************************************
  // Clock, tasks and watchdog
  // ****************************************
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Compares one value and reports a difference at once.
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  // Lets input changes reach the registered outputs.
  task automatic settle();
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : settle

  // Watches the six LEDs for exactly one flash period.
  task automatic measure();
    repeat (3) @(posedge mclk_i);
    clear <= 1'b1;
    @(posedge mclk_i);
    clear <= 1'b0;
    repeat (PER) @(posedge mclk_i);
    #1;
  endtask : measure

  // Waits a bounded time for a power-up phase.
  task automatic wait_phase(input phase_t p);
    for (int n = 0; n < 2000 && phase_o !== p; n++) @(posedge mclk_i);
    #1;
    check(phase_o, p);
  endtask : wait_phase

  task automatic stop_test();
    if (mismatches == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // The whole run needs some one thousand cycles.
  initial begin
    repeat (20000) @(posedge mclk_i);
    mismatches++;
    stop_test();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (16) @(posedge mclk_i);
    #1;
    check(phase_o, PH_INIT);
    rstn_i <= 1'b1;
    wait_phase(PH_SELFTEST);
    settle();
    check(port_traffic_led_o, 16'hffff);
    wait_phase(PH_BOOT);
    settle();
    check(port_link_led_o, 16'h0001);
    boot_done_i <= 1'b1;
    wait_phase(PH_RUN);
    settle();
    check(port_link_led_o, 16'hffff);
    check(port_traffic_led_o, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      {supply2_ok_i, supply1_ok_i} <= 2'(i);
      settle();
      check(power_led_o, pw[i]);
      check(power_single, (i % 2 == 1) ? LED_GREEN : LED_OFF);
    end
    check(ring_manager_led_o, LED_OFF);
    ring_mgr_en_i <= 1'b1;
    ring_port_blocked_i <= 1'b1;
    settle();
    check(ring_manager_led_o, LED_GREEN);
    ring_port_blocked_i <= 1'b0;
    settle();
    check(ring_manager_led_o, LED_YELLOW);
    ring_misconfig_i <= 1'b1;
    measure();
    check(hue[0], LED_GREEN);
    check(rises[0] > 1 && lit[0] < PER, 1'b1);
    ring_misconfig_i <= 1'b0;
    ring_mgr_en_i <= 1'b0;
    standby_en_i <= 1'b1;
    measure();
    check(lit[1], PER);
    check(hue[1], LED_GREEN);
    standby_en_i <= 1'b0;
    mem_op_i <= MEM_ERROR;
    measure();
    check({rises[0][7:0], rises[1][7:0], both[7:0]}, 24'h010100);
    check(lit[0], PER / 2);
    mem_op_i <= MEM_LOAD;
    measure();
    check({rises[0][7:0], rises[1][7:0]}, 16'h0202);
    check(both, lit[0]);
    mem_op_i <= MEM_SAVE;
    measure();
    check({rises[0][7:0], rises[1][7:0]}, 16'h0101);
    check(both, lit[1]);
    mem_op_i <= MEM_IDLE;
    relay1_error_i <= 1'b1;
    measure();
    check({lit[2][7:0], 6'h00, hue[2]}, {8'(PER), 8'h03});
    relay1_error_i <= 1'b0;
    new_release_i <= 1'b1;
    ip_conflict_i <= 1'b1;
    measure();
    check({rises[2][7:0], 6'h00, hue[2]}, 16'h0403);
    ip_conflict_i <= 1'b0;
    relay_open_i <= 2'h3;
    relay_manual_i <= 2'h1;
    settle();
    check({relay_two_led_o, relay_one_led_o}, {LED_GREEN, LED_YELLOW});
    check(fault_led_o, LED_OFF);
    relay_open_i <= 2'h0;
    settle();
    check({relay_two_led_o, relay_one_led_o}, {LED_OFF, LED_OFF});
    new_release_i <= 1'b0;
    relay_manual_i <= 2'h3;
    settle();
    check({relay_two_led_o, relay_one_led_o}, {LED_YELLOW, LED_YELLOW});
    relay_open_i <= 2'h3;
    settle();
    check({relay_two_led_o, relay_one_led_o}, {LED_OFF, LED_OFF});
    check(fault_led_o, LED_OFF);
    port_activity_i <= 16'h0001;
    measure();
    check(rises[5] > 1 && lit[5] < PER, 1'b1);
    port_activity_i <= 16'h0000;
    port_standby_i <= 16'h0001;
    measure();
    check(rises[4], 1);
    port_standby_i <= 16'h0000;
    port_disabled_i <= 16'h0001;
    measure();
    check(rises[4], 3);
    port_disabled_i <= 16'h0000;
    port_link_i <= 16'h0000;
    settle();
    check({port_link_led_o, port_traffic_led_o}, 32'h0);
    stop_test();
  end
endmodule : test_status_led_indicator
